// ---- verilog/msu_pkg.sv ----
// constants, opcode patterns and types shared by the shift unit files
package msu_pkg;

	// ---------------------------------------------------------------
	// widths and field positions
	// ---------------------------------------------------------------
	localparam int WORD_W      = 16;
	localparam int WIDE_W      = 32;
	localparam int SEL_W       = 3;
	localparam int LIT_W       = 4;
	localparam int TGT_LSB     = 0;
	localparam int CNT_SEL_LSB = 3;
	localparam int LIT_LSB     = 3;
	localparam int BYTE_SHIFT  = 8;

	// ---------------------------------------------------------------
	// opcode patterns
	// ---------------------------------------------------------------
	localparam logic [2:0]  TAIL_WIDE        = 3'h5;    // bits 2..0 of wide forms
	localparam logic [9:0]  OPC_WIDE_R_REG   = 10'h0e4; // bits 15..6
	localparam logic [8:0]  OPC_WIDE_R_LIT   = 9'h070;  // bits 15..7
	localparam logic [8:0]  OPC_WIDE_L_LIT   = 9'h071;  // bits 15..7
	localparam logic [9:0]  OPC_SHL_REG      = 10'h0ba; // bits 15..6
	localparam logic [9:0]  OPC_SHLS_REG     = 10'h0b8; // bits 15..6
	localparam logic [9:0]  OPC_SHR_REG      = 10'h0b9; // bits 15..6
	localparam logic [8:0]  OPC_SHLS_LIT     = 9'h058;  // bits 15..7
	localparam logic [8:0]  OPC_SHL_LIT      = 9'h05a;  // bits 15..7
	localparam logic [8:0]  OPC_SHR_LIT      = 9'h059;  // bits 15..7
	localparam logic [12:0] OPC_SHIFT_L_BYTE = 13'h05df; // bits 15..3
	localparam logic [12:0] OPC_SHIFT_R_BYTE = 13'h05de; // bits 15..3

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SM_LEFT16,
		SM_SLEFT16,
		SM_RIGHT16,
		SM_LEFT32,
		SM_RIGHT32
	} msu_step_mode_t;

	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} msu_fsm_t;

	typedef struct packed {
		msu_fsm_t             fsm;
		msu_step_mode_t       mode;
		logic                 wide;
		logic                 left;
		logic [WIDE_W-1:0]    value;
		logic [WORD_W-1:0]    remain;
		logic [SEL_W-1:0]     sel;
		logic                 err;
		logic                 reg_we;
		logic                 pair_we;
		logic                 out_we;
		logic                 ovf_we;
		logic                 loss_we;
		logic                 out_flag;
		logic                 ovf_flag;
		logic                 loss_flag;
	} msu_state_t;

endpackage

// ---- verilog/msu_decode.sv ----
// instruction decoder for the shift unit
`timescale 1ns/1ps
module msu_decode (
	input  wire logic [15:0]               instr,     // instruction word
	output logic                           hit,       // word is a shift handled here
	output logic                           is_lit,    // count comes from the literal
	output logic                           is_byte,   // fixed 8-position form
	output logic                           is_wide,   // operand is the product pair
	output logic                           is_left,   // left shift
	output msu_pkg::msu_step_mode_t        mode,      // one-step shifter mode
	output logic [msu_pkg::LIT_W-1:0]      literal,   // literal count
	output logic [msu_pkg::SEL_W-1:0]      tgt_sel,   // target register
	output logic [msu_pkg::SEL_W-1:0]      cnt_sel    // count register
);

	logic tail_ok;

	assign literal = instr[msu_pkg::LIT_LSB +: msu_pkg::LIT_W];
	assign tgt_sel = instr[msu_pkg::TGT_LSB +: msu_pkg::SEL_W];
	assign cnt_sel = instr[msu_pkg::CNT_SEL_LSB +: msu_pkg::SEL_W];
	assign tail_ok = (instr[2:0] == msu_pkg::TAIL_WIDE);

	always_comb begin
		hit     = 1'b1;
		is_lit  = 1'b0;
		is_byte = 1'b0;
		is_wide = 1'b0;
		is_left = 1'b0;
		mode    = msu_pkg::SM_LEFT16;
		if (instr[15:6] == msu_pkg::OPC_WIDE_R_REG && tail_ok) begin
			is_wide = 1'b1;
			mode    = msu_pkg::SM_RIGHT32;
		end else if (instr[15:7] == msu_pkg::OPC_WIDE_R_LIT && tail_ok) begin
			is_wide = 1'b1;
			is_lit  = 1'b1;
			mode    = msu_pkg::SM_RIGHT32;
		end else if (instr[15:7] == msu_pkg::OPC_WIDE_L_LIT && tail_ok) begin
			is_wide = 1'b1;
			is_lit  = 1'b1;
			is_left = 1'b1;
			mode    = msu_pkg::SM_LEFT32;
		end else if (instr[15:3] == msu_pkg::OPC_SHIFT_L_BYTE) begin
			is_byte = 1'b1;
			is_left = 1'b1;
		end else if (instr[15:3] == msu_pkg::OPC_SHIFT_R_BYTE) begin
			is_byte = 1'b1;
			mode    = msu_pkg::SM_RIGHT16;
		end else if (instr[15:6] == msu_pkg::OPC_SHL_REG) begin
			is_left = 1'b1;
		end else if (instr[15:6] == msu_pkg::OPC_SHLS_REG) begin
			is_left = 1'b1;
			mode    = msu_pkg::SM_SLEFT16;
		end else if (instr[15:6] == msu_pkg::OPC_SHR_REG) begin
			mode    = msu_pkg::SM_RIGHT16;
		end else if (instr[15:7] == msu_pkg::OPC_SHLS_LIT) begin
			is_lit  = 1'b1;
			is_left = 1'b1;
			mode    = msu_pkg::SM_SLEFT16;
		end else if (instr[15:7] == msu_pkg::OPC_SHL_LIT) begin
			is_lit  = 1'b1;
			is_left = 1'b1;
		end else if (instr[15:7] == msu_pkg::OPC_SHR_LIT) begin
			is_lit  = 1'b1;
			mode    = msu_pkg::SM_RIGHT16;
		end else begin
			hit     = 1'b0;
		end
	end

endmodule

// ---- verilog/msu_shift_step.sv ----
// one-position shifter used once per cycle of a multi-cycle shift
`timescale 1ns/1ps
module msu_shift_step (
	input  msu_pkg::msu_step_mode_t        mode,      // shift kind
	input  wire logic [msu_pkg::WIDE_W-1:0] value_in, // operand before the step
	output logic [msu_pkg::WIDE_W-1:0]     value_out, // operand after the step
	output logic                           out_bit,   // bit pushed out
	output logic                           err_bit    // overflow or precision loss
);

	// 16-bit forms keep the upper half zero
	always_comb begin
		value_out = value_in;
		out_bit   = 1'b0;
		err_bit   = 1'b0;
		case (mode)
			msu_pkg::SM_LEFT16: begin
				out_bit   = value_in[15];
				err_bit   = value_in[15];
				value_out = {16'h0000, value_in[14:0], 1'b0};
			end
			msu_pkg::SM_SLEFT16: begin
				// sign stays put, bit 14 leaves; overflow when it differs from sign
				out_bit   = value_in[14];
				err_bit   = value_in[14] ^ value_in[15];
				value_out = {16'h0000, value_in[15], value_in[13:0], 1'b0};
			end
			msu_pkg::SM_RIGHT16: begin
				out_bit   = value_in[0];
				err_bit   = value_in[0];
				value_out = {17'h00000, value_in[15:1]};
			end
			msu_pkg::SM_LEFT32: begin
				out_bit   = value_in[31];
				err_bit   = value_in[31];
				value_out = {value_in[30:0], 1'b0};
			end
			msu_pkg::SM_RIGHT32: begin
				out_bit   = value_in[0];
				err_bit   = value_in[0];
				value_out = {1'b0, value_in[31:1]};
			end
			default: begin
				value_out = value_in;
			end
		endcase
	end

endmodule

// ---- verilog/msu_shift_unit.sv ----
// shift datapath of the microcore arithmetic unit
`timescale 1ns/1ps

// How it works
// - wide operand is high product half above low product half.
// - wide right shift by the selected count register value.
// - wide right shift by the 4-bit literal.
// - wide left shift by the literal, updating shift-out and overflow flags.
// - variable shifts take one clock per position of the count.
// - target shifted left by count register, result written back.
// - signed left shift of target by count register.
// - signed left shifts keep the sign bit, lower bits move.
// - signed left shift of target by the literal.
// - target shifted left by the literal, written back.
// - target shifted right by the literal, written back.
// - target shifted right by count register, written back.
// - target shifted left by eight in one clock.
// - target shifted right by eight.
// - right-by-eight completes in one clock for any value.
// - left shifts update shift-out and overflow flags.
// - right shifts update shift-out and precision-loss flags.
// - literal is four bits; selectors address the arithmetic registers.
module msu_shift_unit (
	input  wire logic                          clock,               // core clock
	input  wire logic                          srst,                // sync reset, high
	input  wire logic                          instr_valid,         // instruction offered
	input  wire logic [15:0]                   instr,               // instruction word
	output logic                               stall,               // hold the sequencer
	output logic                               busy,                // multi-cycle shift running
	output logic [msu_pkg::SEL_W-1:0]          target_sel,          // target read select
	output logic [msu_pkg::SEL_W-1:0]          count_sel,           // count read select
	input  wire logic [msu_pkg::WORD_W-1:0]    target_data,         // target read data
	input  wire logic [msu_pkg::WORD_W-1:0]    count_data,          // count read data
	input  wire logic [msu_pkg::WORD_W-1:0]    high_product_half,   // upper pair half
	input  wire logic [msu_pkg::WORD_W-1:0]    low_product_half,    // lower pair half
	output logic                               reg_we,              // target write pulse
	output logic [msu_pkg::SEL_W-1:0]          reg_wsel,            // target write select
	output logic [msu_pkg::WORD_W-1:0]         reg_wdata,           // target write data
	output logic                               pair_we,             // pair write pulse
	output logic [msu_pkg::WIDE_W-1:0]         pair_wdata,          // pair write data
	output logic                               shifted_out_we,      // shift-out update
	output logic                               left_overflow_we,    // overflow update
	output logic                               precision_loss_we,   // loss update
	output logic                               shifted_out_flag,    // last bit out
	output logic                               left_overflow_flag,  // left overflow
	output logic                               precision_loss_flag  // right loss
);

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic                            dec_hit;
	logic                            dec_lit;
	logic                            dec_byte;
	logic                            dec_wide;
	logic                            dec_left;
	msu_pkg::msu_step_mode_t         dec_mode;
	logic [msu_pkg::LIT_W-1:0]       dec_literal;
	logic [msu_pkg::SEL_W-1:0]       dec_tsel;
	logic [msu_pkg::SEL_W-1:0]       dec_csel;

	msu_decode u_decode (
		.instr   (instr),
		.hit     (dec_hit),
		.is_lit  (dec_lit),
		.is_byte (dec_byte),
		.is_wide (dec_wide),
		.is_left (dec_left),
		.mode    (dec_mode),
		.literal (dec_literal),
		.tgt_sel (dec_tsel),
		.cnt_sel (dec_csel)
	);

	msu_pkg::msu_state_t             state_reg;
	msu_pkg::msu_state_t             state_next;
	logic                            accept;
	logic [msu_pkg::WORD_W-1:0]      count;
	logic [msu_pkg::WIDE_W-1:0]      load_val;
	logic [msu_pkg::WIDE_W-1:0]      pair_in;
	logic [msu_pkg::WIDE_W-1:0]      step_in;
	logic [msu_pkg::WIDE_W-1:0]      step_val;
	logic                            step_out;
	logic                            step_err;
	logic                            err_acc;
	msu_pkg::msu_step_mode_t         step_mode;
	logic [msu_pkg::WIDE_W-1:0]      byte_val;
	logic                            byte_out;
	logic                            byte_err;
	logic                            fin;
	logic [msu_pkg::WIDE_W-1:0]      fin_val;
	logic                            fin_out;
	logic                            fin_err;

	// selectors index the arithmetic register subset
	assign target_sel = dec_tsel;
	assign count_sel  = dec_csel;
	assign accept     = (state_reg.fsm == msu_pkg::ST_IDLE) && instr_valid && dec_hit;
	assign count      = dec_lit ? {12'h000, dec_literal} : count_data;
	assign pair_in    = {high_product_half, low_product_half};
	assign load_val   = dec_wide ? pair_in : {16'h0000, target_data};

	// ---------------------------------------------------------------
	// datapath
	// ---------------------------------------------------------------
	// the first step runs in the accept cycle, so n positions cost n clocks
	assign step_in   = (state_reg.fsm == msu_pkg::ST_IDLE) ? load_val : state_reg.value;
	assign step_mode = (state_reg.fsm == msu_pkg::ST_IDLE) ? dec_mode : state_reg.mode;
	assign err_acc   = (state_reg.fsm == msu_pkg::ST_RUN) ? (state_reg.err | step_err) : step_err;

	msu_shift_step u_step (
		.mode      (step_mode),
		.value_in  (step_in),
		.value_out (step_val),
		.out_bit   (step_out),
		.err_bit   (step_err)
	);

	// byte forms are one wide move, no stepping
	always_comb begin
		if (dec_left) begin
			byte_val = {16'h0000, target_data[7:0], 8'h00};
			byte_out = target_data[msu_pkg::BYTE_SHIFT];
			byte_err = |target_data[15:8];
		end else begin
			byte_val = {24'h000000, target_data[15:8]};
			byte_out = target_data[msu_pkg::BYTE_SHIFT-1];
			byte_err = |target_data[7:0];
		end
	end

	// ---------------------------------------------------------------
	// control
	// ---------------------------------------------------------------
	always_comb begin
		state_next         = state_reg;
		state_next.reg_we  = 1'b0;
		state_next.pair_we = 1'b0;
		state_next.out_we  = 1'b0;
		state_next.ovf_we  = 1'b0;
		state_next.loss_we = 1'b0;
		fin     = 1'b0;
		fin_val = step_val;
		fin_out = step_out;
		fin_err = err_acc;
		case (state_reg.fsm)
			msu_pkg::ST_IDLE: begin
				if (accept) begin
					state_next.mode = dec_mode;
					state_next.wide = dec_wide;
					state_next.left = dec_left;
					state_next.sel  = dec_tsel;
					state_next.err  = step_err;
					if (dec_byte) begin
						fin     = 1'b1;
						fin_val = byte_val;
						fin_out = byte_out;
						fin_err = byte_err;
					end else if (count == 16'h0000) begin
						// zero count leaves the operand and clears the flags
						fin     = 1'b1;
						fin_val = load_val;
						fin_out = 1'b0;
						fin_err = 1'b0;
					end else if (count == 16'h0001) begin
						fin = 1'b1;
					end else begin
						state_next.fsm    = msu_pkg::ST_RUN;
						state_next.value  = step_val;
						state_next.remain = count - 16'h0001;
					end
				end
			end
			msu_pkg::ST_RUN: begin
				state_next.value  = step_val;
				state_next.err    = err_acc;
				state_next.remain = state_reg.remain - 16'h0001;
				if (state_reg.remain == 16'h0001) begin
					fin            = 1'b1;
					state_next.fsm = msu_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next.fsm = msu_pkg::ST_IDLE;
			end
		endcase
		if (fin) begin
			state_next.value    = fin_val;
			state_next.err      = fin_err;
			state_next.reg_we   = !state_next.wide;
			state_next.pair_we  = state_next.wide;
			state_next.out_we   = 1'b1;
			state_next.out_flag = fin_out;
			if (state_next.left) begin
				state_next.ovf_we   = 1'b1;
				state_next.ovf_flag = fin_err;
			end else begin
				state_next.loss_we   = 1'b1;
				state_next.loss_flag = fin_err;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// stall only while more than the accept-cycle step remains
	assign stall = (accept && !dec_byte && (count > 16'h0001))
		|| (state_reg.fsm == msu_pkg::ST_RUN);
	assign busy                = (state_reg.fsm == msu_pkg::ST_RUN);
	assign reg_we              = state_reg.reg_we;
	assign reg_wsel            = state_reg.sel;
	assign reg_wdata           = state_reg.value[msu_pkg::WORD_W-1:0];
	assign pair_we             = state_reg.pair_we;
	assign pair_wdata          = state_reg.value;
	assign shifted_out_we      = state_reg.out_we;
	assign left_overflow_we    = state_reg.ovf_we;
	assign precision_loss_we   = state_reg.loss_we;
	assign shifted_out_flag    = state_reg.out_flag;
	assign left_overflow_flag  = state_reg.ovf_flag;
	assign precision_loss_flag = state_reg.loss_flag;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic                       chk_active;
	logic [msu_pkg::WORD_W:0]   chk_cnt;
	logic [msu_pkg::WORD_W-1:0] chk_len;
	logic                       chk_sign;
	logic                       chk_signed;

	always_ff @(posedge clock) begin
		if (srst) begin
			chk_active <= 1'b0;
			chk_cnt    <= '0;
			chk_len    <= '0;
			chk_sign   <= 1'b0;
			chk_signed <= 1'b0;
		end else if (accept && !dec_byte && (count != 16'h0000)) begin
			chk_active <= 1'b1;
			chk_cnt    <= 17'h00001;
			chk_len    <= count;
			chk_sign   <= target_data[15];
			chk_signed <= (dec_mode == msu_pkg::SM_SLEFT16);
		end else if (chk_active && (reg_we || pair_we)) begin
			chk_active <= 1'b0;
		end else if (chk_active) begin
			chk_cnt <= chk_cnt + 17'h00001;
		end
	end

	sequence seq_accept_byte;
		accept && dec_byte;
	endsequence

	sequence seq_write_next;
		reg_we && !pair_we;
	endsequence

	property p_byte_one_cycle;
		@(posedge clock) disable iff (srst)
		seq_accept_byte |-> !stall ##1 seq_write_next;
	endproperty

	byte_one_cycle_a: assert property (p_byte_one_cycle)
		else $error("byte shift did not finish in one cycle");

	byte_right_a: assert property (@(posedge clock) disable iff (srst)
		(accept && dec_byte && !dec_left) |=> (reg_wdata[15:8] == 8'h00)
		&& (reg_wdata[7:0] == $past(target_data[15:8])))
		else $error("right byte shift result wrong");

	cycle_count_a: assert property (@(posedge clock) disable iff (srst)
		(chk_active && (reg_we || pair_we)) |-> (chk_cnt == {1'b0, chk_len}))
		else $error("shift took the wrong number of cycles");

	stall_hold_a: assert property (@(posedge clock) disable iff (srst)
		(chk_active && !(reg_we || pair_we)) |-> stall)
		else $error("stall dropped before last step");

	sign_keep_a: assert property (@(posedge clock) disable iff (srst)
		(chk_active && chk_signed && reg_we) |-> (reg_wdata[15] == chk_sign))
		else $error("signed left shift changed the sign bit");

	pair_concat_a: assert property (@(posedge clock) disable iff (srst)
		(accept && dec_wide && !dec_left && (count == 16'h0001))
		|=> pair_we && (pair_wdata == ($past(pair_in) >> 1)))
		else $error("wide operand not built from the product halves");

	left_flags_a: assert property (@(posedge clock) disable iff (srst)
		(accept && dec_left) |=> shifted_out_we && left_overflow_we
		|| (stall && !precision_loss_we))
		else $error("left shift flag update missing");

	right_flags_a: assert property (@(posedge clock) disable iff (srst)
		precision_loss_we |-> shifted_out_we && !left_overflow_we)
		else $error("right shift flag update wrong");

	wide_decode_a: assert property (@(posedge clock) disable iff (srst)
		(instr[15:6] == msu_pkg::OPC_WIDE_R_REG && instr[2:0] == msu_pkg::TAIL_WIDE)
		|-> (dec_wide && !dec_lit && !dec_left))
		else $error("wide right by register misdecoded");

	zero_fill_a: assert property (@(posedge clock) disable iff (srst)
		(accept && !dec_wide && !dec_byte && !dec_left && (count == 16'h0002))
		|-> ##2 (reg_we && (reg_wdata[15:14] == 2'b00)))
		else $error("right shift did not fill with zeros");

endmodule

// ---- tb/msu_regfile_model.sv ----
// register file and product pair model facing the shift unit
`timescale 1ns/1ps
module msu_regfile_model (
	input  wire logic        clock,             // core clock
	input  wire logic [2:0]  target_sel,        // target read select
	input  wire logic [2:0]  count_sel,         // count read select
	input  wire logic        reg_we,            // register write
	input  wire logic [2:0]  reg_wsel,          // register write select
	input  wire logic [15:0] reg_wdata,         // register write data
	input  wire logic        pair_we,           // pair write
	input  wire logic [31:0] pair_wdata,        // pair write data
	output logic      [15:0] target_data,       // target read data
	output logic      [15:0] count_data,        // count read data
	output logic      [15:0] high_product_half, // upper pair half
	output logic      [15:0] low_product_half   // lower pair half
);
	logic [15:0] regs [8];
	logic [31:0] pair;
	// forwarding: a read right behind a write must see the new value
	always_comb begin
		target_data = (reg_we && reg_wsel == target_sel) ? reg_wdata : regs[target_sel];
		count_data = (reg_we && reg_wsel == count_sel) ? reg_wdata : regs[count_sel];
		{high_product_half, low_product_half} = pair_we ? pair_wdata : pair;
	end
	// plain always: the bench preloads these arrays between instructions
	always @(posedge clock) begin
		if (reg_we)
			regs[reg_wsel] <= reg_wdata;
		if (pair_we)
			pair <= pair_wdata;
	end
endmodule

// ---- tb/msu_shift_unit_tb.sv ----
// self-checking bench for the shift unit, random and corner instructions
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module msu_shift_unit_tb;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        instr_valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic        stall, busy, reg_we, pair_we, so_we, ov_we, pl_we, so_f, ov_f, pl_f;
	logic [2:0]  tsel, csel, wsel;
	logic [15:0] tdata, cdata, hi, lo, wdata;
	logic [31:0] pwdata;
	logic [31:0] seed = 32'he25d6cdd;
	logic [2:0]  eflag = 3'h0;
	int          fails = 0;
	int          samples_checked = 0;

	always #10 clock = ~clock;

	msu_shift_unit dut_u (.clock(clock), .srst(srst), .instr_valid(instr_valid), .instr(instr),
		.stall(stall), .busy(busy), .target_sel(tsel), .count_sel(csel), .target_data(tdata),
		.count_data(cdata), .high_product_half(hi), .low_product_half(lo), .reg_we(reg_we),
		.reg_wsel(wsel), .reg_wdata(wdata), .pair_we(pair_we), .pair_wdata(pwdata),
		.shifted_out_we(so_we), .left_overflow_we(ov_we), .precision_loss_we(pl_we),
		.shifted_out_flag(so_f), .left_overflow_flag(ov_f), .precision_loss_flag(pl_f));

	msu_regfile_model regf_u (.clock(clock), .target_sel(tsel), .count_sel(csel),
		.reg_we(reg_we), .reg_wsel(wsel), .reg_wdata(wdata), .pair_we(pair_we),
		.pair_wdata(pwdata), .target_data(tdata), .count_data(cdata),
		.high_product_half(hi), .low_product_half(lo));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// returns {last bit out, overflow or loss, result}
	function automatic logic [33:0] calc(input int k, input logic [31:0] v, input int n);
		logic o;
		logic e;
		o = 1'b0;
		e = 1'b0;
		for (int i = 0; i < n; i++) begin
			o = (k == 2) ? v[31] : (k == 4 || k == 6) ? v[14] : (k inside {3, 7, 9}) ? v[15] : v[0];
			if (k == 4 || k == 6) begin
				e |= v[14] ^ v[15];
				v = {16'h0000, v[15], v[13:0], 1'b0};
			end else begin
				e |= o;
				v = (k == 2) ? v << 1 : (k inside {3, 7, 9}) ? {16'h0000, v[14:0], 1'b0} : v >> 1;
			end
		end
		return {o, e, v};
	endfunction

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// one instruction: preload operands, offer it, wait for completion
	// ----------------------------------------------------------------
	task automatic op(input int k, input logic [2:0] t, input logic [2:0] cs, input logic [3:0] lit,
			input logic [15:0] tv, input logic [15:0] cv, input logic [31:0] pv);
		logic [15:0] opc;
		logic [33:0] r;
		int          n, cnt, got;
		bit          wide, left;
		@(posedge clock);
		#2;
		regf_u.regs[t] = tv;
		regf_u.regs[cs] = cv;
		regf_u.pair = pv;
		wide = k < 3;
		left = k inside {2, 3, 4, 6, 7, 9};
		case (k)
			0: opc = {msu_pkg::OPC_WIDE_R_REG, cs, msu_pkg::TAIL_WIDE};
			1: opc = {msu_pkg::OPC_WIDE_R_LIT, lit, msu_pkg::TAIL_WIDE};
			2: opc = {msu_pkg::OPC_WIDE_L_LIT, lit, msu_pkg::TAIL_WIDE};
			3: opc = {msu_pkg::OPC_SHL_REG, cs, t};
			4: opc = {msu_pkg::OPC_SHLS_REG, cs, t};
			5: opc = {msu_pkg::OPC_SHR_REG, cs, t};
			6: opc = {msu_pkg::OPC_SHLS_LIT, lit, t};
			7: opc = {msu_pkg::OPC_SHL_LIT, lit, t};
			8: opc = {msu_pkg::OPC_SHR_LIT, lit, t};
			9: opc = {msu_pkg::OPC_SHIFT_L_BYTE, t};
			default: opc = {msu_pkg::OPC_SHIFT_R_BYTE, t};
		endcase
		cnt = (k inside {0, 3, 4, 5}) ? int'(regf_u.regs[cs]) : (k > 8 ? 8 : int'(lit));
		n = (k > 8 || cnt == 0) ? 1 : cnt;
		r = calc(k, wide ? pv : {16'h0000, regf_u.regs[t]}, cnt);
		got = 0;
		@(posedge clock);
		instr <= opc;
		instr_valid <= 1'b1;
		for (int i = 1; i < 40 && got == 0; i++) begin
			@(posedge clock);
			// kept offered while busy: the unit must ignore it
			instr_valid <= (i < n);
			#1;
			if (reg_we || pair_we) begin
				got = i;
				`CHK({reg_we, pair_we, so_we, ov_we, pl_we}, {!wide, wide, 1'b1, left, !left})
				`CHK({stall, busy}, 2'b00)
				if (left)
					eflag = {r[33:32], eflag[0]};
				else
					eflag = {r[33], eflag[1], r[32]};
				`CHK({so_f, ov_f, pl_f}, eflag)
				if (wide)
					`CHK(pwdata, r[31:0])
				else
					`CHK({wsel, wdata}, {t, r[15:0]})
			end else
				`CHK(stall, 1'b1)
		end
		`CHK(got, n)
	endtask

	initial begin
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		`CHK({reg_we, pair_we, busy, so_f, ov_f, pl_f}, 6'h00)
		// a word outside the shift group is ignored, no stall, no write
		instr <= 16'h2ed9;
		instr_valid <= 1'b1;
		@(posedge clock);
		#1;
		`CHK({reg_we, pair_we, busy, stall}, 4'h0)
		instr_valid <= 1'b0;
		// zero count, beyond width, sign kept, full literal, byte forms
		op(3, 3'h1, 3'h2, 4'h0, 16'h8001, 16'h0000, 32'h0);
		op(4, 3'h3, 3'h4, 4'h0, 16'hc001, 16'h0011, 32'h0);
		op(2, 3'h0, 3'h0, 4'hf, 16'h0, 16'h0, 32'h8000_0001);
		op(1, 3'h0, 3'h0, 4'h1, 16'h0, 16'h0, 32'h0001_0003);
		op(10, 3'h7, 3'h0, 4'h0, 16'h00ff, 16'h0, 32'h0);
		op(9, 3'h6, 3'h0, 4'h0, 16'hffff, 16'h0, 32'h0);
		for (int j = 0; j < 300; j++)
			op(int'(rnd() % 11), 3'(rnd()), 3'(rnd()), 4'(rnd()), 16'(rnd()), 16'(rnd() % 21), rnd());
		wrap_up();
	end

	initial begin
		#(20 * 30000);
		fails++;
		wrap_up();
	end
endmodule
